// ===== dfm_ctrl_model.sv
// Memory controller model issuing mode register commands.
`timescale 1ns/1ns
`default_nettype none
module dfm_ctrl_model
    import dfm_pkg::*;
(
    input wire logic clk_sys,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [ADDR_W-1:0] cmdAddr,
    output logic [DATA_W-1:0] cmdData,
    output logic cke
);
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdAddr = 6'h00;
        cmdData = 8'h00;
        cke = 1'b1;
    end
    // ==========================================
    // Commands
    task automatic setCke(input logic v);
        @(posedge clk_sys);
        cke <= v;
        repeat (4) @(posedge clk_sys);
    endtask
    // Never issues a masked write, and raises CKE first when a training-control write clears bit 0 with CKE low.
    task automatic issue(input logic w, input logic [5:0] a, input logic [7:0] d);
        if (w && a == ADDR_TRAIN_CTRL && !d[BIT_CMD_TRAIN] && !cke) begin
            setCke(1'b1);
        end
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdAddr <= a;
        cmdData <= d;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        // Released lines flip so a stale value is never mistaken for live data.
        cmdAddr <= ~a;
        cmdData <= ~d;
    endtask
    // Write followed by a read of the same address with no idle cycle between them.
    task automatic writeThenRead(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdWrite <= 1'b1;
        cmdAddr <= a;
        cmdData <= d;
        @(posedge clk_sys);
        cmdWrite <= 1'b0;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        cmdAddr <= ~a;
        cmdData <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== dfm_mode_registers.sv
// Mode-register bank for training control and DQ reference setting.
// Operation
// - Writing bit 0 of training control enters command bus training.
// - Training with CKE low ignores commands, mirrors CA inputs onto DQ.
// - Bit 2 set drives internal reference levels onto DQ pins.
// - Reference output shows the operating set point's values, with CA level bit 0 in bit 7.
// - Bit 3 selects high-current fast-settling reference mode.
// - Option bit clear disables refresh codes 001 and 010.
// - Disabled codes are reported as 011 instead.
// - Option bit matters only when device-info bit 0 is one.
// - Bit 5 zero enables data masking; default zero.
// - Duplicated registers accessed only through the access set point copy.
// - Device operates only from operating set point copy.
// - Reference field write goes to set point chosen by bit 6.
// - Read of DQ reference drives eight bits, reserved zero.
// - Range bit persists until overwritten or reset.
`timescale 1ns/1ns
`default_nettype none
module dfm_mode_registers
    import dfm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [DATA_W-1:0] cmdData,
    input wire logic cke,
    input wire logic [5:0] caIn,
    input wire logic [2:0] rawRefreshCode,
    input wire logic infoBit0,
    input wire logic [5:0] caRefLevel,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOutValid,
    output logic cmdTrainActive,
    output logic cmdIgnore,
    output logic preambleTrainEn,
    output logic refOutEn,
    output logic fastSettleEn,
    output logic maskEnable,
    output logic operSetPoint,
    output logic accessSetPoint,
    output logic [2:0] refreshCode,
    output logic [REF_LEVEL_W-1:0] dqRefLevel,
    output logic dqRefRange
);
    // ===========================================================
    // State
    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] dq;
        logic dqValid;
        logic [2:0] ckeSync;
    } dfm_state_t;
    dfm_state_t state_q;
    dfm_state_t state_d;

    logic ckeLow;
    logic cmdTaken;
    logic refWrite;
    logic [6:0] accessValue;
    logic [6:0] operValue;

    // CKE is a pin; it counts as low once the second and third stages both read low.
    assign ckeLow = !state_q.ckeSync[1] && !state_q.ckeSync[2];
    assign cmdTrainActive = state_q.ctrl[BIT_CMD_TRAIN];
    // Commands are dropped while training holds the bus with CKE low.
    assign cmdIgnore = cmdTrainActive && ckeLow;
    assign cmdTaken = cmdValid && !cmdIgnore;
    assign refWrite = cmdTaken && cmdWrite && cmdAddr == ADDR_DQ_REF;

    // ===========================================================
    // Submodules
    dfm_setpoint_pair #(.W(7)) uPair (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wrEn(refWrite),
        .accessSel(state_q.ctrl[BIT_ACCESS_SP]),
        .operSel(state_q.ctrl[BIT_OPER_SP]),
        .wrData(cmdData[6:0]),
        .accessValue(accessValue),
        .operValue(operValue)
    );

    dfm_status_filter uFilter (
        .rawCode(rawRefreshCode),
        .rateOptEn(state_q.ctrl[BIT_RATE_OPT]),
        .infoBit0(infoBit0),
        .reportCode(refreshCode)
    );

    // ===========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        state_d.ckeSync = {state_q.ckeSync[1:0], cke};
        state_d.dqValid = 1'b0;
        if (cmdTaken && cmdWrite && cmdAddr == ADDR_TRAIN_CTRL) begin
            state_d.ctrl = cmdData;
        end
        if (cmdTaken && !cmdWrite && cmdAddr == ADDR_DQ_REF) begin
            state_d.dq = {1'b0, accessValue};
            state_d.dqValid = 1'b1;
        end else if (cmdIgnore) begin
            state_d.dq = {2'b00, caIn};
            state_d.dqValid = 1'b1;
        end else if (state_q.ctrl[BIT_REF_OUT]) begin
            // Bits 5:0 carry DQ level, range in bit 6; bit 7 carries CA level bit 0.
            state_d.dq = {1'b0, operValue};
            state_d.dq[7] = caRefLevel[0];
            state_d.dqValid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q.ctrl <= TRAIN_CTRL_RESET;
            state_q.dq <= '0;
            state_q.dqValid <= 1'b0;
            state_q.ckeSync <= 3'h0;
        end else begin
            state_q <= state_d;
        end
    end

    // ===========================================================
    // Outputs
    assign dqOut = state_q.dq;
    assign dqOutValid = state_q.dqValid;
    assign preambleTrainEn = state_q.ctrl[BIT_PREAMBLE];
    assign refOutEn = state_q.ctrl[BIT_REF_OUT];
    assign fastSettleEn = state_q.ctrl[BIT_FAST_SETTLE];
    assign maskEnable = !state_q.ctrl[BIT_MASK_DIS];
    assign operSetPoint = state_q.ctrl[BIT_OPER_SP];
    assign accessSetPoint = state_q.ctrl[BIT_ACCESS_SP];
    assign dqRefLevel = operValue[REF_LEVEL_W-1:0];
    assign dqRefRange = operValue[BIT_REF_RANGE];

    // ===========================================================
    // Checks
    a_train_enter: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmdTaken && cmdWrite && cmdAddr == ADDR_TRAIN_CTRL && cmdData[BIT_CMD_TRAIN])
        |=> cmdTrainActive) else $error("Training bit not set.");
    a_ca_mirror: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmdIgnore && !(cmdValid && !cmdWrite)) |=> dqOut == {2'b00, $past(caIn)} && dqOutValid)
        else $error("CA not mirrored on DQ.");
    a_ignore_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmdIgnore && cmdValid) |=> $stable(state_q.ctrl))
        else $error("Command taken while ignored.");
    a_fast_settle: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmdTaken && cmdWrite && cmdAddr == ADDR_TRAIN_CTRL)
        |=> fastSettleEn == $past(cmdData[BIT_FAST_SETTLE]))
        else $error("Fast settle not following write.");
    a_mask_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmdTaken && cmdWrite && cmdAddr == ADDR_TRAIN_CTRL)
        |=> maskEnable == !$past(cmdData[BIT_MASK_DIS]))
        else $error("Mask polarity wrong.");
    a_rate_filter: assert property (@(posedge clk_sys) disable iff (!resetn)
        (infoBit0 && !state_q.ctrl[BIT_RATE_OPT]
        && (rawRefreshCode == RATE_CODE_1 || rawRefreshCode == RATE_CODE_2))
        |-> refreshCode == RATE_CODE_3) else $error("Disabled code reported.");
    a_rate_enabled: assert property (@(posedge clk_sys) disable iff (!resetn)
        (infoBit0 && state_q.ctrl[BIT_RATE_OPT]) |-> refreshCode == rawRefreshCode)
        else $error("Enabled code altered.");
    a_rate_indep: assert property (@(posedge clk_sys) disable iff (!resetn)
        !infoBit0 |-> refreshCode == rawRefreshCode)
        else $error("Status depends on option without info bit.");
    a_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
        (refWrite ##1 (cmdValid && !cmdIgnore && !cmdWrite && cmdAddr == ADDR_DQ_REF
        && $stable(accessSetPoint))) |=> dqOut == {1'b0, $past(cmdData[6:0], 2)} && !dqOut[7])
        else $error("Read-back differs from written value.");
    a_preamble_reset: assert property (@(posedge clk_sys)
        $rose(resetn) |-> !preambleTrainEn) else $error("Preamble not clear at reset.");
endmodule
`default_nettype wire

// ===== dfm_mode_registers_tb.sv
// Testbench for the mode-register bank.
`timescale 1ns/1ns
`default_nettype none
module dfm_mode_registers_tb;
    import dfm_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic cmdValid, cmdWrite, cke, infoBit0 = 1'b0, dqOutValid, cmdTrainActive, cmdIgnore;
    logic [5:0] cmdAddr, caIn = 6'h00, caRefLevel = 6'h15, dqRefLevel;
    logic [7:0] cmdData, dqOut;
    logic [2:0] rawRefreshCode = 3'h0, refreshCode;
    logic preambleTrainEn, refOutEn, fastSettleEn, maskEnable, operSetPoint, accessSetPoint;
    logic dqRefRange;
    int errors = 0;
    int num_checks = 0;
    always #20 clk_sys = ~clk_sys;
    dfm_ctrl_model ctrl (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .cke(cke));
    dfm_mode_registers dut (.clk_sys(clk_sys), .resetn(resetn), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cke(cke), .caIn(caIn),
        .rawRefreshCode(rawRefreshCode), .infoBit0(infoBit0), .caRefLevel(caRefLevel),
        .dqOut(dqOut), .dqOutValid(dqOutValid), .cmdTrainActive(cmdTrainActive),
        .cmdIgnore(cmdIgnore), .preambleTrainEn(preambleTrainEn), .refOutEn(refOutEn),
        .fastSettleEn(fastSettleEn), .maskEnable(maskEnable), .operSetPoint(operSetPoint),
        .accessSetPoint(accessSetPoint), .refreshCode(refreshCode), .dqRefLevel(dqRefLevel),
        .dqRefRange(dqRefRange));
    // ==========================================
    // Helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        ctrl.issue(1'b1, a, d);
        #1;
    endtask
    task automatic mrr(input logic [5:0] a);
        ctrl.issue(1'b0, a, 8'h00);
        #1;
    endtask
    // ==========================================
    // Scenarios
    task automatic testResetAndBits();
        chk({4'h0, preambleTrainEn, refOutEn, fastSettleEn, maskEnable}, 8'h01);
        chk({1'b0, dqRefRange, dqRefLevel}, 8'h5D);
        mrw(ADDR_TRAIN_CTRL, 8'h3E);
        chk({4'h0, preambleTrainEn, refOutEn, fastSettleEn, maskEnable}, 8'h0E);
        mrw(ADDR_TRAIN_CTRL, 8'h00);
        chk({4'h0, preambleTrainEn, refOutEn, fastSettleEn, maskEnable}, 8'h01);
    endtask
    task automatic testSetPoints();
        mrw(ADDR_TRAIN_CTRL, 8'h40);
        ctrl.writeThenRead(ADDR_DQ_REF, 8'h8A);
        #1;
        chk(dqOut, 8'h0A);
        chk({7'h00, dqOutValid}, 8'h01);
        chk({1'b0, dqRefRange, dqRefLevel}, 8'h5D);
        mrr(ADDR_DQ_REF);
        chk(dqOut, 8'h0A);
        chk({7'h00, dqOutValid}, 8'h01);
        mrw(ADDR_TRAIN_CTRL, 8'hC0);
        chk({6'h00, operSetPoint, accessSetPoint}, 8'h03);
        chk({1'b0, dqRefRange, dqRefLevel}, 8'h0A);
        mrw(ADDR_TRAIN_CTRL, 8'h80);
        mrr(ADDR_DQ_REF);
        chk(dqOut, 8'h5D);
        mrr(ADDR_TRAIN_CTRL);
        chk({7'h00, dqOutValid}, 8'h00);
    endtask
    task automatic testRefresh();
        for (int i = 0; i < 4; i++) begin
            mrw(ADDR_TRAIN_CTRL, {3'h0, i[0], 4'h0});
            for (int c = 0; c < 8; c++) begin
                @(posedge clk_sys);
                infoBit0 <= i[1];
                rawRefreshCode <= c[2:0];
                #1;
                chk({5'h00, refreshCode}, (i == 2 && (c == 1 || c == 2)) ? 8'h03 : c[7:0]);
            end
        end
    endtask
    task automatic testRefOutAndTraining();
        mrw(ADDR_TRAIN_CTRL, 8'h04);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(dqOut, 8'hDD);
        mrw(ADDR_TRAIN_CTRL, 8'h84);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(dqOut, 8'h8A);
        mrw(ADDR_TRAIN_CTRL, 8'h01);
        chk({7'h00, cmdTrainActive}, 8'h01);
        @(posedge clk_sys);
        caIn <= 6'h2B;
        ctrl.setCke(1'b0);
        #1;
        chk({cmdIgnore, dqOutValid, dqOut[5:0]}, 8'hEB);
        // Keeps the training bit set so the model does not raise CKE first.
        ctrl.issue(1'b1, ADDR_TRAIN_CTRL, 8'h21);
        #1;
        chk({6'h00, cmdTrainActive, maskEnable}, 8'h03);
        chk({cmdIgnore, dqOutValid, dqOut[5:0]}, 8'hEB);
        mrw(ADDR_TRAIN_CTRL, 8'h00);
        chk({7'h00, cmdTrainActive}, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        testResetAndBits();
        testSetPoints();
        testRefresh();
        testRefOutAndTraining();
        complete_run();
    end
    // Cuts a hang short and reports it as a mismatch.
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire

// ===== dfm_pkg.sv
// Package with mode-register addresses, field positions and reset values.
package dfm_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] ADDR_TRAIN_CTRL = 6'h0D;
    localparam logic [5:0] ADDR_DQ_REF = 6'h0E;
    // Training and set-point control bit positions.
    localparam int BIT_CMD_TRAIN = 0;
    localparam int BIT_PREAMBLE = 1;
    localparam int BIT_REF_OUT = 2;
    localparam int BIT_FAST_SETTLE = 3;
    localparam int BIT_RATE_OPT = 4;
    localparam int BIT_MASK_DIS = 5;
    localparam int BIT_ACCESS_SP = 6;
    localparam int BIT_OPER_SP = 7;
    // DQ reference field layout.
    localparam int REF_LEVEL_W = 6;
    localparam int BIT_REF_RANGE = 6;
    localparam logic [7:0] TRAIN_CTRL_RESET = 8'h00;
    // Default level 011101b, range 1.
    localparam logic [6:0] DQ_REF_RESET = 7'h5D;
    localparam logic [2:0] RATE_CODE_1 = 3'h1;
    localparam logic [2:0] RATE_CODE_2 = 3'h2;
    localparam logic [2:0] RATE_CODE_3 = 3'h3;
    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_READ = 2'b10
    } dfm_cmd_t;
endpackage

// ===== dfm_setpoint_pair.sv
// Two set-point copies of the DQ reference setting.
`timescale 1ns/1ns
`default_nettype none
module dfm_setpoint_pair
    import dfm_pkg::*;
#(
    parameter int W = 7
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic wrEn,
    input wire logic accessSel,
    input wire logic operSel,
    input wire logic [W-1:0] wrData,
    output logic [W-1:0] accessValue,
    output logic [W-1:0] operValue
);
    typedef struct packed {
        logic [1:0][W-1:0] copy;
    } dfm_pair_state_t;
    dfm_pair_state_t state_q;
    dfm_pair_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (wrEn) begin
            state_d.copy[accessSel] = wrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q.copy[0] <= W'(DQ_REF_RESET);
            state_q.copy[1] <= W'(DQ_REF_RESET);
        end else begin
            state_q <= state_d;
        end
    end

    assign accessValue = state_q.copy[accessSel];
    assign operValue = state_q.copy[operSel];

    a_inactive_copy_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wrEn && accessSel != operSel) |=> $stable(operValue) || $changed(operSel))
        else $error("Write to inactive set point disturbed operating copy.");
endmodule
`default_nettype wire

// ===== dfm_status_filter.sv
// Refresh-rate code filter for the temperature status field.
`timescale 1ns/1ns
`default_nettype none
module dfm_status_filter
    import dfm_pkg::*;
(
    input wire logic [2:0] rawCode,
    input wire logic rateOptEn,
    input wire logic infoBit0,
    output logic [2:0] reportCode
);
    always_comb begin
        reportCode = rawCode;
        if (infoBit0 && !rateOptEn) begin
            if (rawCode == RATE_CODE_1 || rawCode == RATE_CODE_2) begin
                reportCode = RATE_CODE_3;
            end
        end
    end
endmodule
`default_nettype wire
